// file: hdl/t2cr_pkg.sv
// Purpose: shared constants and types for the capture/reload timer
// Assumes: sys_clk is the oscillator, one machine cycle is twelve clocks
// Notes:   the special function register port is eight bits wide
package t2cr_pkg;

  // ****************************************************************
  // register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_CONTROL     = 8'hc8;
  localparam logic [7:0] ADDR_CAPTURE_LOW = 8'hca;
  localparam logic [7:0] ADDR_CAPTURE_HI  = 8'hcb;
  localparam logic [7:0] ADDR_COUNT_LOW   = 8'hcc;
  localparam logic [7:0] ADDR_COUNT_HI    = 8'hcd;

  // ****************************************************************
  // control register fields and reset values
  // ****************************************************************
  localparam int BIT_OVERFLOW_FLAG   = 7;
  localparam int BIT_EXT_EVENT_FLAG  = 6;
  localparam int BIT_RX_CLOCK_SELECT = 5;
  localparam int BIT_TX_CLOCK_SELECT = 4;
  localparam int BIT_EXT_TRIG_ENABLE = 3;
  localparam int BIT_RUN_CONTROL     = 2;
  localparam int BIT_COUNT_SOURCE    = 1;
  localparam int BIT_CAPTURE_RELOAD  = 0;

  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] CAPTURE_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX     = 16'hffff;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int         OSC_PER_MACHINE_CYCLE = 12;
  localparam logic [3:0] PRESCALE_LAST = 4'(OSC_PER_MACHINE_CYCLE - 1);
  localparam int         BAUD_DIVIDE   = 16;
  localparam logic [3:0] BAUD_LAST     = 4'(BAUD_DIVIDE - 1);

  // ****************************************************************
  // state types
  // ****************************************************************
  typedef struct packed {
    logic [3:0] div;
    logic       tick;
  } t2cr_prescale_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic sampled;
    logic fall;
  } t2cr_sync_t;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] capture;
    logic [7:0]  control;
    logic [3:0]  baudDiv;
    logic        overflowPulse;
    logic        baudTick;
    logic [7:0]  readData;
  } t2cr_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } t2cr_sfr_req_t;

endpackage : t2cr_pkg

// file: hdl/t2cr_prescale.sv
// Purpose: machine cycle enable, one pulse every twelve oscillator clocks
// Assumes: srst synchronous, active high
// Notes:   free running, not gated by the run control bit
`timescale 1ns/100ps
module t2cr_prescale (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // machine cycle enable
  output logic      machineTick
);

  t2cr_pkg::t2cr_prescale_t st_r;
  t2cr_pkg::t2cr_prescale_t st_nxt;

  // ****************************************************************
  // divider
  // ****************************************************************
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.div == t2cr_pkg::PRESCALE_LAST) begin
      st_nxt.div  = 4'h0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.div = st_r.div + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign machineTick = st_r.tick;

endmodule : t2cr_prescale

// file: hdl/t2cr_edge_sync.sv
// Purpose: two stage synchroniser plus machine cycle falling edge sampler
// Assumes: pin is asynchronous to sys_clk
// Notes:   a level must stand one machine cycle to be seen
`timescale 1ns/100ps
module t2cr_edge_sync (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // sampling enable
  input  wire logic sampleTick,
  // pin and result
  input  wire logic pinIn,
  output logic      fallPulse
);

  t2cr_pkg::t2cr_sync_t st_r;
  t2cr_pkg::t2cr_sync_t st_nxt;

  // ****************************************************************
  // synchronise and sample
  // ****************************************************************
  always_comb begin
    st_nxt       = st_r;
    st_nxt.sync1 = pinIn;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.fall  = 1'b0;
    if (sampleTick) begin
      st_nxt.sampled = st_r.sync2;
      st_nxt.fall    = st_r.sampled & ~st_r.sync2;
    end
  end

  // idle high so a pin low at release is seen as an edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= 4'b1110;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fallPulse = st_r.fall;

endmodule : t2cr_edge_sync

// file: hdl/t2cr_timer.sv
// Purpose: sixteen bit timer/counter with capture, auto-reload and baud modes
// Assumes: sys_clk is the oscillator; special function register port is
//          same clock; port b clock selects come from the power control reg
// Notes:   read data appears one clock after the read strobe
//
// How it works
// - source bit picks oscillator or pin edges
// - internal twelfth rate; pin edges at most 24th
// - capture mode counts sixteen bits, sets overflow
// - capture mode counts upward only
// - capture mode trigger fall copies count into capture pair
// - capturing trigger fall sets external event flag
// - reload mode overflow sets flag, loads capture
// - reload mode trigger fall reloads, sets flag
// - trigger ignored while trigger enable clear
// - any baud select forces reload on overflow
// - baud mode overflow never sets overflow flag
// - baud mode trigger fall is extra interrupt
// - flags cleared only by software control writes
// - external event flag requests timer interrupt
// - run bit starts, clearing stops every mode
// - rx select routes overflow to port a rx
// - tx select routes overflow to port a tx
// - power control bits route to port b
// - baud reload from capture, rate over sixteen
// - baud mode trigger sets flag, no reload
`timescale 1ns/100ps
module t2cr_timer (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // special function register port
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWr,
  input  wire logic       sfrRd,
  input  wire logic [7:0] sfrWdata,
  output logic      [7:0] sfrRdata,
  // pins
  input  wire logic       eventCountInput,
  input  wire logic       triggerInput,
  // port b clock selects from power control
  input  wire logic       rxClockSelectPortB,
  input  wire logic       txClockSelectPortB,
  // serial port clocking
  output logic            overflowPulse,
  output logic            baudTick,
  output logic            rxClockSelect,
  output logic            txClockSelect,
  output logic            portBRxFromTimer,
  output logic            portBTxFromTimer,
  // interrupt request
  output logic            timerIrq
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  t2cr_pkg::t2cr_state_t   st_r;
  t2cr_pkg::t2cr_state_t   st_nxt;
  t2cr_pkg::t2cr_sfr_req_t req;
  logic                    machineTick;
  logic                    countFall;
  logic                    trigFall;
  logic                    baudMode;
  logic                    countEn;
  logic                    overflow;
  logic                    trigger;
  logic                    reloadMode;
  logic                    wrControl;
  logic                    wrCount;
  logic                    wrCapture;
  logic [7:0]              controlBase;

  assign req = '{addr: sfrAddr, wr: sfrWr, rd: sfrRd, wdata: sfrWdata};

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic hit(input t2cr_pkg::t2cr_sfr_req_t r,
                               input logic [7:0] a);
    hit = r.wr & (r.addr == a);
  endfunction : hit

  // ****************************************************************
  // submodules
  // ****************************************************************
  t2cr_prescale u_prescale (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .machineTick (machineTick)
  );

  t2cr_edge_sync u_count_sync (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .sampleTick (machineTick),
    .pinIn      (eventCountInput),
    .fallPulse  (countFall)
  );

  t2cr_edge_sync u_trig_sync (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .sampleTick (machineTick),
    .pinIn      (triggerInput),
    .fallPulse  (trigFall)
  );

  // ****************************************************************
  // decode of the current mode
  // ****************************************************************
  // baud selects override mode
  assign baudMode = st_r.control[t2cr_pkg::BIT_RX_CLOCK_SELECT]
                  | st_r.control[t2cr_pkg::BIT_TX_CLOCK_SELECT]
                  | rxClockSelectPortB
                  | txClockSelectPortB;
  assign reloadMode = baudMode | ~st_r.control[t2cr_pkg::BIT_CAPTURE_RELOAD];

  assign countEn = st_r.control[t2cr_pkg::BIT_RUN_CONTROL]
                 & (st_r.control[t2cr_pkg::BIT_COUNT_SOURCE] ? countFall : machineTick);
  assign overflow = countEn & (st_r.count == t2cr_pkg::COUNT_MAX);

  assign trigger = st_r.control[t2cr_pkg::BIT_EXT_TRIG_ENABLE] & trigFall;

  assign wrControl = hit(req, t2cr_pkg::ADDR_CONTROL);
  assign wrCount   = hit(req, t2cr_pkg::ADDR_COUNT_LOW) | hit(req, t2cr_pkg::ADDR_COUNT_HI);
  assign wrCapture = hit(req, t2cr_pkg::ADDR_CAPTURE_LOW)
                   | hit(req, t2cr_pkg::ADDR_CAPTURE_HI);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_nxt               = st_r;
    st_nxt.overflowPulse = 1'b0;
    st_nxt.baudTick      = 1'b0;
    controlBase          = wrControl ? req.wdata : st_r.control;

    if (countEn) begin
      st_nxt.count = st_r.count + 16'h0001;
    end
    if (overflow && reloadMode) begin
      st_nxt.count = st_r.capture;
    end
    if (trigger && !baudMode && !st_r.control[t2cr_pkg::BIT_CAPTURE_RELOAD]) begin
      st_nxt.count = st_r.capture;
    end
    if (trigger && !baudMode && st_r.control[t2cr_pkg::BIT_CAPTURE_RELOAD]) begin
      st_nxt.capture = st_r.count;
    end

    // software writes win over counting
    if (hit(req, t2cr_pkg::ADDR_COUNT_LOW)) begin
      st_nxt.count[7:0] = req.wdata;
    end
    if (hit(req, t2cr_pkg::ADDR_COUNT_HI)) begin
      st_nxt.count[15:8] = req.wdata;
    end
    if (hit(req, t2cr_pkg::ADDR_CAPTURE_LOW)) begin
      st_nxt.capture[7:0] = req.wdata;
    end
    if (hit(req, t2cr_pkg::ADDR_CAPTURE_HI)) begin
      st_nxt.capture[15:8] = req.wdata;
    end

    st_nxt.control = controlBase;
    st_nxt.control[t2cr_pkg::BIT_OVERFLOW_FLAG] =
        controlBase[t2cr_pkg::BIT_OVERFLOW_FLAG] | (overflow & ~baudMode);
    st_nxt.control[t2cr_pkg::BIT_EXT_EVENT_FLAG] =
        controlBase[t2cr_pkg::BIT_EXT_EVENT_FLAG] | trigger;

    st_nxt.overflowPulse = overflow;
    if (overflow && baudMode) begin
      st_nxt.baudDiv = st_r.baudDiv + 4'h1;
      st_nxt.baudTick = (st_r.baudDiv == t2cr_pkg::BAUD_LAST);
    end

    if (req.rd) begin
      case (req.addr)
        t2cr_pkg::ADDR_CONTROL:     st_nxt.readData = st_r.control;
        t2cr_pkg::ADDR_COUNT_LOW:   st_nxt.readData = st_r.count[7:0];
        t2cr_pkg::ADDR_COUNT_HI:    st_nxt.readData = st_r.count[15:8];
        t2cr_pkg::ADDR_CAPTURE_LOW: st_nxt.readData = st_r.capture[7:0];
        t2cr_pkg::ADDR_CAPTURE_HI:  st_nxt.readData = st_r.capture[15:8];
        default:                    st_nxt.readData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= '{count:         t2cr_pkg::COUNT_RESET,
                capture:       t2cr_pkg::CAPTURE_RESET,
                control:       t2cr_pkg::CONTROL_RESET,
                baudDiv:       4'h0,
                overflowPulse: 1'b0,
                baudTick:      1'b0,
                readData:      8'h00};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign sfrRdata      = st_r.readData;
  assign overflowPulse = st_r.overflowPulse;
  assign baudTick      = st_r.baudTick;
  assign rxClockSelect = st_r.control[t2cr_pkg::BIT_RX_CLOCK_SELECT];
  assign txClockSelect = st_r.control[t2cr_pkg::BIT_TX_CLOCK_SELECT];
  assign portBRxFromTimer = rxClockSelectPortB;
  assign portBTxFromTimer = txClockSelectPortB;
  assign timerIrq = st_r.control[t2cr_pkg::BIT_OVERFLOW_FLAG]
                  | st_r.control[t2cr_pkg::BIT_EXT_EVENT_FLAG];

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence seqTickGap;
    ##1 !machineTick [*8] ##1 !machineTick [*3] ##1 machineTick;
  endsequence

  sequence seqFlagSet;
    ##1 st_r.control[t2cr_pkg::BIT_OVERFLOW_FLAG] && timerIrq;
  endsequence

  sequence seqPulseOnce;
    ##1 overflowPulse ##1 !overflowPulse;
  endsequence

  sequence seqFallQuiet;
    ##1 !countFall [*8] ##1 !countFall [*8] ##1 !countFall [*7];
  endsequence

  chk_tick_spacing: assert property (
    machineTick |-> seqTickGap)
    else $error("machine tick spacing is not twelve clocks");

  chk_internal_step: assert property (
    countEn && !st_r.control[t2cr_pkg::BIT_COUNT_SOURCE] && !overflow
      && !wrCount && !trigger
    |=> st_r.count == $past(st_r.count) + 16'h0001)
    else $error("internal count did not step by one");

  chk_run_stop: assert property (
    !st_r.control[t2cr_pkg::BIT_RUN_CONTROL] && !wrCount && !trigger
    |=> st_r.count == $past(st_r.count))
    else $error("count moved while stopped");

  chk_overflow_flag: assert property (
    overflow && !baudMode |-> seqFlagSet)
    else $error("overflow did not set flag and request");

  chk_baud_no_flag: assert property (
    baudMode && !st_r.control[t2cr_pkg::BIT_OVERFLOW_FLAG] && !wrControl
    |=> !st_r.control[t2cr_pkg::BIT_OVERFLOW_FLAG])
    else $error("overflow flag set in baud mode");

  chk_reload_value: assert property (
    overflow && reloadMode && !wrCount
    |=> st_r.count == $past(st_r.capture))
    else $error("rollover did not reload from capture pair");

  chk_capture_copy: assert property (
    trigger && !baudMode && st_r.control[t2cr_pkg::BIT_CAPTURE_RELOAD] && !wrCapture
    |=> st_r.capture == $past(st_r.count))
    else $error("trigger edge did not capture count");

  chk_event_flag: assert property (
    trigger |=> st_r.control[t2cr_pkg::BIT_EXT_EVENT_FLAG] && timerIrq)
    else $error("trigger edge did not set event flag");

  chk_trig_ignored: assert property (
    trigFall && !st_r.control[t2cr_pkg::BIT_EXT_TRIG_ENABLE] && !wrCapture
    |=> st_r.capture == $past(st_r.capture))
    else $error("disabled trigger changed capture pair");

  chk_flag_sticky: assert property (
    st_r.control[t2cr_pkg::BIT_EXT_EVENT_FLAG] && !wrControl
    |=> st_r.control[t2cr_pkg::BIT_EXT_EVENT_FLAG])
    else $error("event flag cleared without a write");

  chk_baud_no_trig: assert property (
    trigger && baudMode && !countEn && !wrCount
    |=> st_r.count == $past(st_r.count))
    else $error("baud mode trigger reloaded the count");

  chk_baud_divide: assert property (
    baudTick |-> $past(st_r.baudDiv) == t2cr_pkg::BAUD_LAST && $past(overflow))
    else $error("baud tick not on sixteenth overflow");

  chk_trig_reload: assert property (
    trigger && !baudMode && !st_r.control[t2cr_pkg::BIT_CAPTURE_RELOAD] && !wrCount
    |=> st_r.count == $past(st_r.capture))
    else $error("reload mode trigger did not load capture pair");

  chk_capture_wrap: assert property (
    overflow && !reloadMode && !wrCount
    |=> st_r.count == 16'h0000)
    else $error("capture mode overflow did not wrap to zero");

  chk_pin_idle: assert property (
    st_r.control[t2cr_pkg::BIT_COUNT_SOURCE] && !countFall && !wrCount && !trigger
    |=> st_r.count == $past(st_r.count))
    else $error("pin count moved without a pin edge");

  chk_pin_rate: assert property (
    countFall |-> seqFallQuiet)
    else $error("pin edges closer than two machine cycles");

  chk_pulse_once: assert property (
    overflow |-> seqPulseOnce)
    else $error("overflow pulse not exactly one cycle");

  chk_trig_no_reload: assert property (
    trigFall && !st_r.control[t2cr_pkg::BIT_EXT_TRIG_ENABLE] && !countEn && !wrCount
    |=> st_r.count == $past(st_r.count))
    else $error("disabled trigger moved the count");

  chk_ovf_sticky: assert property (
    st_r.control[t2cr_pkg::BIT_OVERFLOW_FLAG] && !wrControl
    |=> st_r.control[t2cr_pkg::BIT_OVERFLOW_FLAG])
    else $error("overflow flag cleared without a write");

endmodule : t2cr_timer

// file: dv/t2cr_serial_peer.sv
// Purpose: serial port clock side, holds the port b power control selects
// Assumes: select changes requested by the bench, one cycle strobe
// Notes:   counts the baud ticks that port b receive would take
`timescale 1ns/100ps
module t2cr_serial_peer (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // power control request
  input  wire logic       pcWr,
  input  wire logic [1:0] pcData,
  output logic            rxClockSelectPortB,
  output logic            txClockSelectPortB,
  // timer side
  input  wire logic       baudTick,
  input  wire logic       portBRxFromTimer,
  output logic      [7:0] portBRxClocks
);
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rxClockSelectPortB <= 1'b0;
      txClockSelectPortB <= 1'b0;
      portBRxClocks      <= 8'h00;
    end else begin
      if (pcWr) begin
        rxClockSelectPortB <= pcData[1];
        txClockSelectPortB <= pcData[0];
      end
      // ticks only count while the timer is the chosen source
      if (baudTick && portBRxFromTimer) begin
        portBRxClocks <= portBRxClocks + 8'h01;
      end
    end
  end
endmodule : t2cr_serial_peer

// file: dv/test_timer2_capture_reload.sv
// Purpose: register level test of the capture/reload timer
// Assumes: inputs change 5 ns after the rising edge
// Notes:   timer is stopped or counting pin edges when count or capture bytes are checked
`timescale 1ns/100ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, got, exp); end end
module test_timer2_capture_reload;
  logic       sys_clk, srst, sfrWr, sfrRd, eventCountInput, triggerInput, pcWr;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata, portBRxClocks;
  logic [1:0] pcData;
  logic       overflowPulse, baudTick, rxClockSelect, txClockSelect, timerIrq;
  logic       rxSelB, txSelB, portBRxFromTimer, portBTxFromTimer;
  int         fail_count  = 0;
  int         checks_done = 0;
  int         n;

  t2cr_timer u_dut (.sys_clk(sys_clk), .srst(srst), .sfrAddr(sfrAddr), .sfrWr(sfrWr),
    .sfrRd(sfrRd), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
    .eventCountInput(eventCountInput), .triggerInput(triggerInput),
    .rxClockSelectPortB(rxSelB), .txClockSelectPortB(txSelB),
    .overflowPulse(overflowPulse), .baudTick(baudTick), .rxClockSelect(rxClockSelect),
    .txClockSelect(txClockSelect), .portBRxFromTimer(portBRxFromTimer),
    .portBTxFromTimer(portBTxFromTimer), .timerIrq(timerIrq));

  t2cr_serial_peer u_peer (.sys_clk(sys_clk), .srst(srst), .pcWr(pcWr), .pcData(pcData),
    .rxClockSelectPortB(rxSelB), .txClockSelectPortB(txSelB), .baudTick(baudTick),
    .portBRxFromTimer(portBRxFromTimer), .portBRxClocks(portBRxClocks));

  // ****************************************************************
  // bus and pin tasks
  // ****************************************************************
  task automatic stop_test();
    $display("checks %0d, errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #5;
    sfrAddr  = a;
    sfrWdata = d;
    sfrWr    = 1'b1;
    @(posedge sys_clk);
    #5;
    sfrWr = 1'b0;
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    #5;
    sfrAddr = a;
    sfrRd   = 1'b1;
    @(posedge sys_clk);
    #5;
    sfrRd = 1'b0;
    `CHK(sfrRdata, e)
  endtask : rdChk

  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask : wr16

  // bounded wait for a one cycle pulse, returns cycles waited
  task automatic waitPulse(input bit useBaud, input int limit, output int cyc);
    cyc = 0;
    do begin
      @(posedge sys_clk);
      #5;
      cyc++;
    end while ((useBaud ? baudTick : overflowPulse) !== 1'b1 && cyc < limit);
    if ((useBaud ? baudTick : overflowPulse) !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: pulse wait ran out", $time);
      stop_test();
    end
  endtask : waitPulse

  // levels held well past two machine cycles so every sample sees them
  task automatic fallPin(input bit onTrig);
    if (onTrig) triggerInput = 1'b0;
    else eventCountInput = 1'b0;
    repeat (30) @(posedge sys_clk);
    #5;
    if (onTrig) triggerInput = 1'b1;
    else eventCountInput = 1'b1;
    repeat (30) @(posedge sys_clk);
    #5;
  endtask : fallPin

  // ****************************************************************
  // clock, watchdog, sequence
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    $display("unexpected at %0t: run too long", $time);
    stop_test();
  end

  initial begin
    srst = 1'b1;
    {sfrWr, sfrRd, pcWr} = 3'h0;
    {sfrAddr, sfrWdata, pcData} = 18'h0;
    {eventCountInput, triggerInput} = 2'b11;
    repeat (16) @(posedge sys_clk);
    #5;
    srst = 1'b0;
    // reset values, unmapped place reads zero and ignores writes
    for (int i = 0; i < 6; i++) rdChk(8'hc8 + 8'(i), 8'h00);
    wr(8'hc9, 8'hff);
    rdChk(8'hc9, 8'h00);
    // capture mode wraps to zero and sets the overflow flag
    wr16(t2cr_pkg::ADDR_COUNT_LOW, 16'hfffe);
    wr(t2cr_pkg::ADDR_CONTROL, 8'h05);
    waitPulse(1'b0, 100, n);
    rdChk(t2cr_pkg::ADDR_CONTROL, 8'h85);
    `CHK(timerIrq, 1'b1)
    wr(t2cr_pkg::ADDR_CONTROL, 8'h01);
    rdChk(t2cr_pkg::ADDR_COUNT_HI, 8'h00);
    rdChk(t2cr_pkg::ADDR_CONTROL, 8'h01);
    `CHK(timerIrq, 1'b0)
    // trigger disabled, then capturing
    wr16(t2cr_pkg::ADDR_COUNT_LOW, 16'habcd);
    fallPin(1'b1);
    rdChk(t2cr_pkg::ADDR_CAPTURE_LOW, 8'h00);
    rdChk(t2cr_pkg::ADDR_CONTROL, 8'h01);
    wr(t2cr_pkg::ADDR_CONTROL, 8'h09);
    fallPin(1'b1);
    rdChk(t2cr_pkg::ADDR_CAPTURE_LOW, 8'hcd);
    rdChk(t2cr_pkg::ADDR_CAPTURE_HI, 8'hab);
    rdChk(t2cr_pkg::ADDR_CONTROL, 8'h49);
    // reload on trigger, then on overflow
    wr(t2cr_pkg::ADDR_CONTROL, 8'h08);
    wr16(t2cr_pkg::ADDR_CAPTURE_LOW, 16'h1234);
    wr16(t2cr_pkg::ADDR_COUNT_LOW, 16'h0000);
    fallPin(1'b1);
    rdChk(t2cr_pkg::ADDR_COUNT_LOW, 8'h34);
    rdChk(t2cr_pkg::ADDR_CONTROL, 8'h48);
    wr16(t2cr_pkg::ADDR_COUNT_LOW, 16'hffff);
    wr(t2cr_pkg::ADDR_CONTROL, 8'h04);
    waitPulse(1'b0, 100, n);
    rdChk(t2cr_pkg::ADDR_CONTROL, 8'h84);
    wr(t2cr_pkg::ADDR_CONTROL, 8'h00);
    rdChk(t2cr_pkg::ADDR_COUNT_LOW, 8'h34);
    rdChk(t2cr_pkg::ADDR_COUNT_HI, 8'h12);
    rdChk(t2cr_pkg::ADDR_CONTROL, 8'h00);
    // pin edges counted only while running
    wr(t2cr_pkg::ADDR_CONTROL, 8'h02);
    wr16(t2cr_pkg::ADDR_COUNT_LOW, 16'h0000);
    fallPin(1'b0);
    rdChk(t2cr_pkg::ADDR_COUNT_LOW, 8'h00);
    wr(t2cr_pkg::ADDR_CONTROL, 8'h06);
    repeat (3) fallPin(1'b0);
    rdChk(t2cr_pkg::ADDR_COUNT_LOW, 8'h03);
    // port b select forces reload even with capture bit set
    @(posedge sys_clk);
    #5;
    {pcWr, pcData} = 3'b111;
    @(posedge sys_clk);
    #5;
    pcWr = 1'b0;
    wr16(t2cr_pkg::ADDR_CAPTURE_LOW, 16'hfff0);
    wr16(t2cr_pkg::ADDR_COUNT_LOW, 16'hfff0);
    wr(t2cr_pkg::ADDR_CONTROL, 8'h05);
    waitPulse(1'b0, 400, n);
    waitPulse(1'b0, 400, n);
    `CHK(n, 192)
    `CHK(portBRxFromTimer, 1'b1)
    `CHK(portBTxFromTimer, 1'b1)
    rdChk(t2cr_pkg::ADDR_CONTROL, 8'h05);
    waitPulse(1'b1, 4000, n);
    waitPulse(1'b1, 4000, n);
    `CHK(n, 3072)
    // peer counts the tick on the edge after it shows
    @(posedge sys_clk);
    #5;
    `CHK(portBRxClocks, 8'h02)
    // port a baud mode, trigger only flags
    wr(t2cr_pkg::ADDR_CONTROL, 8'h38);
    wr16(t2cr_pkg::ADDR_COUNT_LOW, 16'h0042);
    fallPin(1'b1);
    rdChk(t2cr_pkg::ADDR_COUNT_LOW, 8'h42);
    rdChk(t2cr_pkg::ADDR_CONTROL, 8'h78);
    `CHK(rxClockSelect, 1'b1)
    `CHK(txClockSelect, 1'b1)
    `CHK(timerIrq, 1'b1)
    stop_test();
  end
endmodule : test_timer2_capture_reload
